// file: rtl/mbrm_pkg.sv
// Package for the Modbus TCP slave register map: offsets, resets, types
package mbrm_pkg;

  // TCP port on which the slave listens
  localparam logic [15:0] MBRM_TCP_PORT      = 16'h01F6;

  // Word addresses of the register map
  localparam logic [15:0] MBRM_IN_BASE       = 16'h0000;
  localparam logic [15:0] MBRM_IN_LAST       = 16'h00FF;
  localparam logic [15:0] MBRM_OUT_BASE      = 16'h0800;
  localparam logic [15:0] MBRM_OUT_LAST      = 16'h08FF;
  localparam logic [15:0] MBRM_IDENT_BASE    = 16'h1000;
  localparam logic [15:0] MBRM_IDENT_LAST    = 16'h1006;
  localparam logic [15:0] MBRM_PLC_IN        = 16'h100A;
  localparam logic [15:0] MBRM_DIAG_IN       = 16'h100B;
  localparam logic [15:0] MBRM_STATUS        = 16'h100C;
  localparam logic [15:0] MBRM_AO_BITS       = 16'h1010;
  localparam logic [15:0] MBRM_AI_BITS       = 16'h1011;
  localparam logic [15:0] MBRM_DO_BITS       = 16'h1012;
  localparam logic [15:0] MBRM_DI_BITS       = 16'h1013;
  localparam logic [15:0] MBRM_WD_ELAPSED    = 16'h1020;
  localparam logic [15:0] MBRM_PLC_OUT       = 16'h110A;
  localparam logic [15:0] MBRM_DIAG_OUT      = 16'h110B;
  localparam logic [15:0] MBRM_WD_TIMEOUT    = 16'h1120;
  localparam logic [15:0] MBRM_WD_UNLOCK     = 16'h1121;
  localparam logic [15:0] MBRM_WD_TYPE       = 16'h1122;
  localparam logic [15:0] MBRM_SPEED_MODE    = 16'h1123;

  // Reset values
  localparam logic [15:0] MBRM_WD_TIMEOUT_RST = 16'h03E8;
  localparam logic        MBRM_WD_TYPE_RST    = 1'b1;
  localparam logic        MBRM_SPEED_RST      = 1'b0;

  // Unlock key pair
  localparam logic [15:0] MBRM_KEY_FIRST     = 16'hBECF;
  localparam logic [15:0] MBRM_KEY_SECOND    = 16'hAFFE;

  // Status word bit positions
  localparam int MBRM_ST_FIELDBUS = 15;
  localparam int MBRM_ST_CONFIG   = 1;
  localparam int MBRM_ST_TERMINAL = 0;

  // Modbus function codes and exception handling
  localparam logic [7:0] MBRM_FC_RD_HOLD   = 8'h03;
  localparam logic [7:0] MBRM_FC_RD_INPUT  = 8'h04;
  localparam logic [7:0] MBRM_FC_WR_SINGLE = 8'h06;
  localparam logic [7:0] MBRM_FC_WR_MULTI  = 8'h10;
  localparam logic [7:0] MBRM_EXC_FLAG     = 8'h80;
  localparam logic [7:0] MBRM_EXC_FUNC     = 8'h01;
  localparam logic [7:0] MBRM_EXC_ADDR     = 8'h02;
  localparam logic [7:0] MBRM_EXC_DEVICE   = 8'h04;
  localparam logic [7:0] MBRM_LEN_HIGH     = 8'h00;

  // Timing: one millisecond tick at 25 MHz
  localparam int MBRM_CLK_HZ   = 25000000;
  localparam int MBRM_TICK_MS  = 1;
  localparam int MBRM_MS_CYC   = MBRM_CLK_HZ / 1000 * MBRM_TICK_MS;

  // Arbitrary identification word value
  localparam logic [15:0] MBRM_IDENT_DEF = 16'h5A01;

  // One decoded register request from the protocol engine
  typedef struct packed {
    logic        valid;     // Request present
    logic [15:0] trans_id;  // Transaction identifier
    logic [7:0]  unit_id;   // Unit identifier
    logic [7:0]  func;      // Function code
    logic [15:0] addr;      // Word address
    logic [15:0] wdata;     // Write data
    logic [31:0] client;    // Client identity (IP address)
  } mbrm_req_s;

  // Reply header and payload word
  typedef struct packed {
    logic        valid;     // Reply present
    logic [15:0] trans_id;  // Echoed transaction identifier
    logic [15:0] proto_id;  // Always zero
    logic [7:0]  len_hi;    // Zero for short messages
    logic [7:0]  len_lo;    // Bytes following byte 5
    logic [7:0]  unit_id;   // Echoed unit identifier
    logic [7:0]  func;      // Function code, 0x80 added on error
    logic [7:0]  exc;       // Exception code when in error
    logic [15:0] rdata;     // Read data word
  } mbrm_rsp_s;

  // Watchdog states
  typedef enum logic [2:0] {
    MBRM_WD_IDLE    = 3'b001,
    MBRM_WD_RUN     = 3'b010,
    MBRM_WD_EXPIRED = 3'b100
  } mbrm_wd_e;

endpackage

// file: rtl/mbrm_slave.sv
// Modbus TCP slave register map with communication watchdog
`timescale 1ns/1ps

// Summary of operation
// - Slave listens on TCP port 502
// - Echo transaction id; protocol id zero
// - Length high zero, low counts following bytes
// - Echo unit identifier unchanged
// - Function code at byte 7, data follows
// - Inputs at words 0x0000 to 0x00FF
// - Outputs at words 0x0800 to 0x08FF
// - Words 0x1010-0x1013 report image lengths
// - Word 0x1020 reports elapsed watchdog ms
// - Word 0x1120 timeout, default 1000 ms
// - Enabled; starts on first write outside words 0x1120 and 0x1121, retriggers
// - Other clients never retrigger watchdog
// - Word 0x1122 selects any or write retrigger
// - Zero timeout disables watchdog
// - Timeout writable only while watchdog inactive
// - Unlock with 0xBECF then 0xAFFE writes
// - Status bit 15 flags watchdog elapsed
// - Status bits 1, 0 config, terminal errors
// - Word 0x1123 mode, effective after coupler restart
// - PLC interface at 0x100A and 0x110A
// - Diagnostics delivered only when enabled; only the 0x100B read is gated, diag_out_word is always driven
// - Errors answer function plus 0x80
module mbrm_slave #(
  parameter int          IN_WORDS  = 256,  // Input image words
  parameter int          OUT_WORDS = 256,  // Output image words
  parameter logic [15:0] IDENT     = mbrm_pkg::MBRM_IDENT_DEF // Arbitrary
) (
  input  wire logic               mclk,
  input  wire logic               reset,
  input  wire logic [15:0]        tcp_port,
  input  wire mbrm_pkg::mbrm_req_s req,
  input  wire logic [15:0]        in_word,
  output logic [7:0]              in_index,
  output mbrm_pkg::mbrm_rsp_s     rsp,
  output logic [15:0]             out_word,
  output logic [7:0]              out_index,
  output logic                    out_write,
  input  wire logic [7:0]         out_rd_index,
  output logic [15:0]             out_rd_word,
  input  wire logic [15:0]        plc_in_word,
  output logic [15:0]             plc_out_word,
  input  wire logic [15:0]        diag_in_word,
  output logic [15:0]             diag_out_word,
  input  wire logic               diag_enable,
  input  wire logic               config_error_flag,
  input  wire logic               terminal_error_flag,
  input  wire logic [15:0]        ao_bits,
  input  wire logic [15:0]        ai_bits,
  input  wire logic [15:0]        do_bits,
  input  wire logic [15:0]        di_bits,
  output logic                    fieldbus_error_flag,
  output logic                    fast_mode_active,
  input  wire logic               coupler_restart
);
  import mbrm_pkg::*;

  // Elaboration check: the 8-bit word index serves exactly 256 words
  if (IN_WORDS != 256 || OUT_WORDS != 256) begin : g_bad_depth
    $error("Image depth must be 256 words");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State record

  typedef struct packed {
    mbrm_rsp_s   rsp;         // Registered reply
    mbrm_wd_e    wd;          // Watchdog state
    logic [15:0] wd_ms;       // Elapsed milliseconds
    logic [14:0] tick;        // Millisecond prescaler
    logic [15:0] timeout;     // Programmed timeout
    logic        wd_type;     // 1 any telegram, 0 writes only
    logic        mode_req;    // Requested speed mode
    logic        mode_act;    // Mode in effect
    logic [31:0] owner;       // Client that started the watchdog
    logic        key_seen;    // First unlock key accepted
    logic        fb_err;      // Sticky fieldbus error
    logic [15:0] plc_out;     // PLC interface output word
    logic [15:0] diag_out;    // Diagnostic interface output word
    logic [15:0] oword;       // Output write data
    logic [7:0]  oidx;        // Output write index
    logic        owr;         // Output write strobe
  } mbrm_state_s;

  mbrm_state_s st;        // Current state
  mbrm_state_s next_st;   // Next state

  logic [15:0] out_mem [OUT_WORDS];  // Process output image

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  logic is_write;     // Request writes a register
  logic is_read;      // Request reads a register
  logic port_ok;      // Connection on the Modbus port
  logic same_client;  // Request from watchdog owner
  logic [15:0] rd;    // Read data mux
  logic rd_ok;        // Read address mapped
  logic wr_ok;        // Write address mapped

  assign port_ok  = (tcp_port == MBRM_TCP_PORT);
  assign is_write = (req.func == MBRM_FC_WR_SINGLE) ||
                    (req.func == MBRM_FC_WR_MULTI);
  assign is_read  = (req.func == MBRM_FC_RD_HOLD) ||
                    (req.func == MBRM_FC_RD_INPUT);
  assign same_client = (req.client == st.owner);
  assign in_index    = req.addr[7:0];
  assign out_rd_word = out_mem[out_rd_index];

  // Read multiplexer over the word map
  always_comb begin
    rd    = 16'h0000;
    rd_ok = 1'b1;
    if (req.addr <= MBRM_IN_LAST) begin
      rd = in_word;
    end else if (req.addr >= MBRM_OUT_BASE && req.addr <= MBRM_OUT_LAST) begin
      rd = out_mem[req.addr[7:0]];
    end else if (req.addr >= MBRM_IDENT_BASE &&
                 req.addr <= MBRM_IDENT_LAST) begin
      rd = IDENT;
    end else begin
      case (req.addr)
        MBRM_PLC_IN:     rd = plc_in_word;
        MBRM_DIAG_IN:    rd = diag_enable ? diag_in_word : 16'h0000;
        MBRM_STATUS: begin
          rd[MBRM_ST_FIELDBUS] = st.fb_err;
          rd[MBRM_ST_CONFIG]   = config_error_flag;
          rd[MBRM_ST_TERMINAL] = terminal_error_flag;
        end
        MBRM_AO_BITS:    rd = ao_bits;
        MBRM_AI_BITS:    rd = ai_bits;
        MBRM_DO_BITS:    rd = do_bits;
        MBRM_DI_BITS:    rd = di_bits;
        MBRM_WD_ELAPSED: rd = st.wd_ms;
        MBRM_PLC_OUT:    rd = st.plc_out;
        MBRM_DIAG_OUT:   rd = st.diag_out;
        MBRM_WD_TIMEOUT: rd = st.timeout;
        MBRM_WD_TYPE:    rd = {15'h0000, st.wd_type};
        MBRM_SPEED_MODE: rd = {15'h0000, st.mode_req};
        default:         rd_ok = 1'b0;
      endcase
    end
  end

  // Writable addresses; the timeout word only while watchdog is not running
  always_comb begin
    wr_ok = 1'b0;
    if (req.addr >= MBRM_OUT_BASE && req.addr <= MBRM_OUT_LAST) begin
      wr_ok = 1'b1;
    end else begin
      case (req.addr)
        MBRM_PLC_OUT, MBRM_DIAG_OUT, MBRM_WD_UNLOCK,
        MBRM_WD_TYPE, MBRM_SPEED_MODE: wr_ok = 1'b1;
        MBRM_WD_TIMEOUT: wr_ok = (st.wd != MBRM_WD_RUN);
        default:         wr_ok = 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb begin
    next_st           = st;
    next_st.rsp.valid = 1'b0;
    next_st.owr       = 1'b0;

    // Millisecond prescaler and elapsed counter
    if (st.wd == MBRM_WD_RUN) begin
      if (st.tick == 15'(MBRM_MS_CYC - 1)) begin
        next_st.tick  = 15'h0000;
        next_st.wd_ms = st.wd_ms + 16'h0001;
      end else begin
        next_st.tick = st.tick + 15'h0001;
      end
      if (st.timeout == 16'h0000) begin
        next_st.wd = MBRM_WD_IDLE;
      end else if (st.wd_ms >= st.timeout) begin
        next_st.wd     = MBRM_WD_EXPIRED;
        next_st.fb_err = 1'b1;
      end
    end

    // Mode change takes effect on coupler restart only
    if (coupler_restart) begin
      next_st.mode_act = st.mode_req;
    end

    if (req.valid && port_ok) begin
      // Reply header
      next_st.rsp.valid    = 1'b1;
      next_st.rsp.trans_id = req.trans_id;
      next_st.rsp.proto_id = 16'h0000;
      next_st.rsp.len_hi   = MBRM_LEN_HIGH;
      next_st.rsp.unit_id  = req.unit_id;
      next_st.rsp.func     = req.func;
      next_st.rsp.exc      = 8'h00;
      next_st.rsp.rdata    = 16'h0000;
      next_st.rsp.len_lo   = 8'h06;

      if (!is_read && !is_write) begin
        next_st.rsp.func   = req.func | MBRM_EXC_FLAG;
        next_st.rsp.exc    = MBRM_EXC_FUNC;
        next_st.rsp.len_lo = 8'h03;
      end else if ((is_read && !rd_ok) || (is_write && !wr_ok)) begin
        next_st.rsp.func   = req.func | MBRM_EXC_FLAG;
        next_st.rsp.exc    = MBRM_EXC_ADDR;
        next_st.rsp.len_lo = 8'h03;
      end else if (is_write && st.fb_err &&
                   req.addr >= MBRM_OUT_BASE && req.addr <= MBRM_OUT_LAST) begin
        // Outputs are locked while the fieldbus error stands
        next_st.rsp.func   = req.func | MBRM_EXC_FLAG;
        next_st.rsp.exc    = MBRM_EXC_DEVICE;
        next_st.rsp.len_lo = 8'h03;
      end else if (is_read) begin
        next_st.rsp.rdata  = rd;
        next_st.rsp.len_lo = 8'h05;
      end else begin
        // Register writes
        if (req.addr >= MBRM_OUT_BASE && req.addr <= MBRM_OUT_LAST) begin
          next_st.oword = req.wdata;
          next_st.oidx  = req.addr[7:0];
          next_st.owr   = 1'b1;
        end
        case (req.addr)
          MBRM_PLC_OUT:    next_st.plc_out  = req.wdata;
          MBRM_DIAG_OUT:   next_st.diag_out = req.wdata;
          MBRM_WD_TIMEOUT: next_st.timeout  = req.wdata;
          MBRM_WD_TYPE:    next_st.wd_type  = req.wdata[0];
          MBRM_SPEED_MODE: next_st.mode_req = req.wdata[0];
          MBRM_WD_UNLOCK: begin
            // Only an expired watchdog is unlocked; an expiry in the
            // same cycle is not lost since the sticky flag is still clear
            if (st.key_seen && st.fb_err &&
                req.wdata == MBRM_KEY_SECOND) begin
              next_st.key_seen = 1'b0;
              next_st.fb_err   = 1'b0;
              next_st.wd       = MBRM_WD_IDLE;
              next_st.wd_ms    = 16'h0000;
              next_st.tick     = 15'h0000;
            end else begin
              next_st.key_seen = (req.wdata == MBRM_KEY_FIRST);
            end
          end
          default: next_st.key_seen = st.key_seen;
        endcase
      end

      // Watchdog start and retrigger
      if (st.wd == MBRM_WD_IDLE && is_write && st.timeout != 16'h0000 &&
          req.addr != MBRM_WD_UNLOCK && req.addr != MBRM_WD_TIMEOUT) begin
        next_st.wd    = MBRM_WD_RUN;
        next_st.owner = req.client;
        next_st.wd_ms = 16'h0000;
        next_st.tick  = 15'h0000;
      end else if (st.wd == MBRM_WD_RUN && same_client &&
                   (st.wd_type || is_write)) begin
        next_st.wd_ms = 16'h0000;
        next_st.tick  = 15'h0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st          <= '0;
      st.wd       <= MBRM_WD_IDLE;
      st.timeout  <= MBRM_WD_TIMEOUT_RST;
      st.wd_type  <= MBRM_WD_TYPE_RST;
      st.mode_req <= MBRM_SPEED_RST;
      st.mode_act <= MBRM_SPEED_RST;
    end else begin
      st <= next_st;
    end
  end

  // Output image store; no reset since it is plain memory
  always_ff @(posedge mclk) begin
    if (st.owr) begin
      out_mem[st.oidx] <= st.oword;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign rsp                 = st.rsp;
  assign out_word            = st.oword;
  assign out_index           = st.oidx;
  assign out_write           = st.owr;
  assign plc_out_word        = st.plc_out;
  assign diag_out_word       = st.diag_out;
  assign fieldbus_error_flag = st.fb_err;
  assign fast_mode_active    = st.mode_act;

endmodule // mbrm_slave

// file: testbench/mbrm_slave_props.sv
// Checker of reply timing, header echo and watchdog status of the slave
`timescale 1ns/1ps
module mbrm_slave_props (
  input wire logic                mclk,
  input wire logic                reset,
  input wire logic [15:0]         tcp_port,
  input wire mbrm_pkg::mbrm_req_s req,
  input wire logic [15:0]         in_word,
  input wire mbrm_pkg::mbrm_rsp_s rsp,
  input wire logic [15:0]         out_word,
  input wire logic [7:0]          out_index,
  input wire logic                out_write,
  input wire logic                fieldbus_error_flag,
  input wire logic                fast_mode_active,
  input wire logic                coupler_restart
);
  import mbrm_pkg::*;
  logic taken; // Request accepted at this edge
  assign taken = req.valid && tcp_port == MBRM_TCP_PORT;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  a_reply_taken: assert property (taken |=> rsp.valid)
    else $error("no reply after accepted request");
  a_reply_refused: assert property (!taken |=> !rsp.valid)
    else $error("reply without accepted request");
  a_trans_echo: assert property (
    taken |=> rsp.trans_id == $past(req.trans_id) && rsp.proto_id == 0)
    else $error("transaction id not echoed");
  a_length_high: assert property (rsp.valid |-> rsp.len_hi == 0)
    else $error("length high byte not zero");
  a_unit_echo: assert property (
    taken |=> rsp.unit_id == $past(req.unit_id))
    else $error("unit id not echoed");
  // Codes outside the served set must come back flagged
  a_bad_func: assert property (
    taken && !(req.func inside {8'h03, 8'h04, 8'h06, 8'h10}) |=>
    rsp.func == ($past(req.func) | 8'h80) && rsp.exc == 8'h01)
    else $error("unknown function not refused");
  a_input_read: assert property (
    taken && req.func == 8'h04 && req.addr <= 16'h00FF |=>
    rsp.rdata == $past(in_word))
    else $error("input word not returned");
  a_output_write: assert property (
    taken && req.func == 8'h06 && req.addr[15:8] == 8'h08 &&
    !fieldbus_error_flag |=> out_write &&
    {8'h00, out_index} == ($past(req.addr) & 16'h00FF) &&
    out_word == $past(req.wdata))
    else $error("output write not issued");
  // Only an unlock write may end a fieldbus error
  a_fb_hold: assert property (
    fieldbus_error_flag && !(taken && req.addr == 16'h1121) |=>
    fieldbus_error_flag)
    else $error("fieldbus error dropped without unlock");
  a_mode_hold: assert property (
    !coupler_restart |=> $stable(fast_mode_active))
    else $error("mode changed without restart");
endmodule // mbrm_slave_props

// file: testbench/mbrm_client.sv
// Modbus TCP client model issuing one register service per frame
`timescale 1ns/1ps
module mbrm_client (
  input  wire logic          mclk,
  output mbrm_pkg::mbrm_req_s req,
  output logic [15:0]        tcp_port
);
  import mbrm_pkg::*;
  // Idle until the bench asks for a service
  initial begin
    req      = '0;
    tcp_port = 16'h0000;
  end
  // One service, valid for one cycle, changed at the falling edge
  task automatic send(input logic [15:0] pt, input logic [31:0] cl,
                      input logic [15:0] tid, input logic [7:0] uid,
                      input logic [7:0] fc, input logic [15:0] ad,
                      input logic [15:0] wd);
    @(negedge mclk);
    tcp_port = pt;
    req      = '{1'b1, tid, uid, fc, ad, wd, cl};
    @(negedge mclk);
    // Released fields flip so a stale value is never mistaken for data
    req       = ~req;
    req.valid = 1'b0;
    tcp_port  = ~tcp_port;
  endtask
endmodule // mbrm_client

// file: testbench/tb.sv
// Random and corner-case bench for the Modbus TCP slave register map
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb;
  import mbrm_pkg::*;
  localparam logic [31:0] CL_A = 32'h0A000001; // Watchdog owner
  localparam logic [31:0] CL_B = 32'h0A000002; // Unrelated client
  localparam logic [7:0]  RH   = MBRM_FC_RD_HOLD;
  logic        mclk, reset, out_write, diag_enable, coupler_restart;
  logic        config_error_flag, terminal_error_flag;
  logic        fieldbus_error_flag, fast_mode_active;
  logic [15:0] tcp_port, in_word, out_word, out_rd_word, a, d;
  logic [15:0] plc_in_word, plc_out_word, diag_in_word, diag_out_word;
  logic [7:0]  in_index, out_index, out_rd_index;
  logic [15:0] img [4];
  mbrm_req_s   req;
  mbrm_rsp_s   rsp;
  int          n_errors, n_checks, i, k;
  // Input image answers with a pattern tied to its index
  assign in_word = {~in_index, in_index};
  mbrm_slave u_dut (.mclk, .reset, .tcp_port, .req, .in_word, .in_index,
    .rsp, .out_word, .out_index, .out_write, .out_rd_index, .out_rd_word,
    .plc_in_word, .plc_out_word, .diag_in_word, .diag_out_word,
    .diag_enable, .config_error_flag, .terminal_error_flag,
    .ao_bits(img[0]), .ai_bits(img[1]), .do_bits(img[2]),
    .di_bits(img[3]), .fieldbus_error_flag, .fast_mode_active,
    .coupler_restart);
  mbrm_client u_cli (.mclk, .req, .tcp_port);
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  ////////////////////////////////////////////////////////////
  // Reply length after byte 5: exception, read or write
  function automatic logic [7:0] exp_len(input logic [7:0] fc, ex);
    if (ex != 8'h00) return 8'h03;
    return (fc == RH || fc == MBRM_FC_RD_INPUT) ? 8'h05 : 8'h06;
  endfunction
  // One service with fresh header ids; the reply header is checked
  task automatic xact(input logic [31:0] cl, input logic [7:0] fc,
                      input logic [15:0] ad, wd, input logic [7:0] ex);
    logic [15:0] tid;
    logic [7:0]  uid;
    tid = 16'($urandom);
    uid = 8'($urandom);
    u_cli.send(MBRM_TCP_PORT, cl, tid, uid, fc, ad, wd);
    `CHK(rsp.valid, 1'b1)
    `CHK(rsp.trans_id, tid)
    `CHK(rsp.proto_id, 16'h0000)
    `CHK(rsp.len_lo, exp_len(fc, ex))
    `CHK(rsp.unit_id, uid)
    `CHK(rsp.func, (ex == 0) ? fc : (fc | MBRM_EXC_FLAG))
    if (ex != 8'h00) `CHK(rsp.exc, ex)
  endtask
  task automatic rd(input logic [15:0] ad, input logic [7:0] fc,
                    input logic [15:0] ev);
    xact(CL_A, fc, ad, 16'h0000, 8'h00);
    `CHK(rsp.rdata, ev)
  endtask
  task automatic wr(input logic [15:0] ad, wd, input logic [7:0] ex);
    xact(CL_A, MBRM_FC_WR_SINGLE, ad, wd, ex);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(79042));
    {n_errors, n_checks} = '0;
    {reset, diag_enable, coupler_restart, out_rd_index} = {3'b110, 8'h00};
    {config_error_flag, terminal_error_flag} = 2'($urandom);
    plc_in_word  = 16'($urandom);
    diag_in_word = 16'($urandom);
    foreach (img[j]) img[j] = 16'($urandom);
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    rd(MBRM_WD_TIMEOUT, RH, MBRM_WD_TIMEOUT_RST);
    rd(MBRM_WD_TYPE, RH, 16'h0001);
    rd(MBRM_SPEED_MODE, RH, 16'h0000);
    rd(MBRM_WD_ELAPSED, RH, 16'h0000);
    d = {14'h0, config_error_flag, terminal_error_flag};
    rd(MBRM_STATUS, RH, d);
    for (k = 0; k < 4; k++) rd(MBRM_AO_BITS + 16'(k), RH, img[k]);
    rd(MBRM_PLC_IN, RH, plc_in_word);
    rd(MBRM_DIAG_IN, RH, diag_in_word);
    diag_enable = 1'b0;
    rd(MBRM_DIAG_IN, RH, 16'h0000);
    diag_enable = 1'b1;
    // A one millisecond timeout keeps an expiry inside the run
    wr(MBRM_WD_TIMEOUT, 16'h0001, 8'h00);
    rd(MBRM_WD_TIMEOUT, RH, 16'h0001);
    xact(CL_A, 8'h2B, 16'h0000, 16'h0000, MBRM_EXC_FUNC);
    xact(CL_A, RH, 16'h0100, 16'h0000, MBRM_EXC_ADDR);
    u_cli.send(16'd503, CL_A, 16'h1234, 8'h01, RH, 16'h0, 16'h0);
    `CHK(rsp.valid, 1'b0)
    for (k = 0; k < 5; k++) begin
      a = (k == 0) ? MBRM_IN_LAST : {8'h00, 8'($urandom)};
      rd(a, MBRM_FC_RD_INPUT, {~a[7:0], a[7:0]});
    end
    d = 16'($urandom);
    wr(MBRM_PLC_OUT, d, 8'h00);
    @(negedge mclk);
    `CHK(plc_out_word, d)
    d = 16'($urandom);
    wr(MBRM_DIAG_OUT, d, 8'h00);
    @(negedge mclk);
    `CHK(diag_out_word, d)
    wr(MBRM_SPEED_MODE, 16'h0001, 8'h00);
    `CHK(fast_mode_active, 1'b0)
    coupler_restart = 1'b1;
    @(negedge mclk);
    coupler_restart = 1'b0;
    @(negedge mclk);
    `CHK(fast_mode_active, 1'b1)
    for (k = 0; k < 5; k++) begin
      a = (k == 0) ? MBRM_OUT_LAST : {8'h08, 8'($urandom)};
      d = 16'($urandom);
      wr(a, d, 8'h00);
      `CHK(({out_write, out_index, out_word}), ({1'b1, a[7:0], d}))
      @(negedge mclk);
      out_rd_index = a[7:0];
      #1 `CHK(out_rd_word, d)
      rd(a, RH, d);
    end
    wr(MBRM_WD_TIMEOUT, 16'h0005, MBRM_EXC_ADDR);
    // The owner restarts the count before each timeout runs out
    repeat (2) begin
      repeat (15000) @(negedge mclk);
      rd(MBRM_WD_ELAPSED, RH, 16'h0000);
    end
    `CHK(fieldbus_error_flag, 1'b0)
    // Another client's traffic must not hold off the expiry
    for (i = 0; i < 30000 && fieldbus_error_flag !== 1'b1; i++) begin
      if (i % 8000 == 100) xact(CL_B, RH, MBRM_WD_TYPE, 16'h0, 8'h00);
      @(negedge mclk);
    end
    if (i >= 30000) begin
      n_errors++;
      wrap_up;
    end
    `CHK((i inside {[20000:25100]}), 1'b1)
    d = {1'b1, 13'h0, config_error_flag, terminal_error_flag};
    rd(MBRM_STATUS, RH, d);
    wr(MBRM_OUT_BASE, 16'h1111, MBRM_EXC_DEVICE);
    wr(MBRM_WD_UNLOCK, MBRM_KEY_SECOND, 8'h00);
    `CHK(fieldbus_error_flag, 1'b1)
    wr(MBRM_WD_UNLOCK, MBRM_KEY_FIRST, 8'h00);
    `CHK(fieldbus_error_flag, 1'b1)
    xact(CL_A, MBRM_FC_WR_MULTI, MBRM_WD_UNLOCK, MBRM_KEY_SECOND, 8'h00);
    @(negedge mclk);
    `CHK(fieldbus_error_flag, 1'b0)
    wr(MBRM_WD_TIMEOUT, 16'h0000, 8'h00);
    wr(MBRM_OUT_BASE, 16'h2222, 8'h00);
    repeat (26000) @(negedge mclk);
    `CHK(fieldbus_error_flag, 1'b0)
    rd(MBRM_WD_ELAPSED, RH, 16'h0000);
    wr(MBRM_WD_TYPE, 16'h0000, 8'h00);
    rd(MBRM_WD_TYPE, RH, 16'h0000);
    wrap_up;
  end
endmodule // tb
bind mbrm_slave mbrm_slave_props u_props (.mclk, .reset, .tcp_port, .req,
  .in_word, .rsp, .out_word, .out_index, .out_write, .fieldbus_error_flag,
  .fast_mode_active, .coupler_restart);
